/* File: lxgc_top.sv */
// global configuration register bank with serial host port
// Functional notes
// RULE1 - writing 0 to reset bit resets, pins unsampled
// RULE2 - soft reset halts transmit, clears filters, defaults
// RULE3 - host writes 1 to leave soft reset
// RULE4 - rate field: 01 line, 10 free, 11 tristate
// RULE5 - auto maintenance on: state machine drives bits
// RULE6 - auto maintenance off: host register drives bits
// RULE7 - auto embedded ops on: manual registers ignored
// RULE8 - embedded ops accept only addresses 000, 111
// RULE9 - activation bit falling starts one attempt
// RULE10 - attempt finished sets activation bit to 1
// RULE11 - serial clock low at reset release: attempt
// RULE12 - host rewrites 0 for each further attempt
// RULE13 - line interface config resets to 0xEF
// RULE14 - two-byte serial frame, device returns data only
// RULE15 - host writes 1 to reserved top bit
`timescale 1ns/1ps
`include "lxgc_defs.svh"
module lxgc_top
(
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic serialClk,
   input wire logic serialDataIn,
   input wire logic serialSelN,
   output logic serialDataOut,
   output logic serialDataOutOe,
   output logic [7:0] lineInterfaceConfig,
   output logic lineTxEnable,
   output logic filterCoefClear,
   output logic dividedClockOutput,
   output logic dividedClockOutputOe,
   input wire logic lineActive,
   input wire logic lineRateTick,
   input wire logic [5:0] maintenanceBitControlReg,
   input wire logic [5:0] fsmMaintBits,
   output logic [5:0] maintBitsOut,
   input wire logic [7:0] embeddedOpsAddressControl,
   input wire logic [7:0] embeddedOpsInfoControl,
   output logic embeddedOpsEngineEnable,
   output logic [7:0] embeddedOpsAddrOut,
   output logic [7:0] embeddedOpsInfoOut,
   input wire logic [2:0] eocRxAddr,
   input wire logic eocRxValid,
   output logic eocRxAccept,
   output logic activationStart,
   input wire logic activationDone
);
   localparam int NW = `LXGC_NCO_W;
   localparam logic [63:0] INC_LINE64 =
      (64'd2 * 64'(`LXGC_LINE_CLK_KHZ) << NW) / 64'(`LXGC_SYS_CLK_KHZ);
   localparam logic [63:0] INC_FREE64 =
      (64'd2 * 64'(`LXGC_FREE_CLK_KHZ) << NW) / 64'(`LXGC_SYS_CLK_KHZ);
   localparam logic [NW-1:0] INC_LINE = INC_LINE64[NW-1:0];
   localparam logic [NW-1:0] INC_FREE = INC_FREE64[NW-1:0];

   lxgc_port_if pif ();

   // pin synchronisers
   logic [2:0] pinMeta_q;
   logic [2:0] pinSync_q;
   logic [2:0] pinRaw;
   assign pinRaw = {serialSelN, serialDataIn, serialClk};
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++)
      begin : g_sync
         always_ff @(posedge clk_sys)
         begin
            pinMeta_q[gi] <= pinRaw[gi];
            pinSync_q[gi] <= pinMeta_q[gi];
         end
      end
   endgenerate
   assign pif.sckS = pinSync_q[0];
   assign pif.sdiS = pinSync_q[1];
   assign pif.csNS = pinSync_q[2];

   lxgc_serial_port u_port
   (
      .clk_sys(clk_sys),
      .pif(pif)
   );
   assign serialDataOut = pif.sdo;
   assign serialDataOutOe = pif.sdoOe;

   // register bank
   logic [7:0] gdc_q, gdc_d;
   logic [7:0] lic_q, lic_d;
   logic actPrev_q, actPrev_d;
   logic rstPrev_q, rstPrev_d;
   lxgc_pkg::lxgc_act_t act_q, act_d;
   logic softRst;
   logic wrGdc;
   logic wrLic;
   logic actFall;

   assign softRst = ~gdc_q[`LXGC_BIT_RESET];
   assign wrGdc = pif.wrStb && pif.addr == `LXGC_GDC_ADDR;
   assign wrLic = pif.wrStb && pif.addr == `LXGC_LIC_ADDR;
   assign actFall = actPrev_q & ~gdc_q[`LXGC_BIT_ACT_TRIG];
   assign pif.rdData = (pif.addr == `LXGC_GDC_ADDR) ? gdc_q :
      (pif.addr == `LXGC_LIC_ADDR) ? lic_q : 8'h00;

   always_comb
   begin
      gdc_d = gdc_q;
      lic_d = lic_q;
      act_d = act_q;
      actPrev_d = gdc_q[`LXGC_BIT_ACT_TRIG];
      rstPrev_d = 1'b0;
      if (wrGdc)
      begin
         gdc_d = pif.wrData;
         gdc_d[`LXGC_BIT_FIXED] = 1'b1;
      end
      if (wrLic)
      begin
         lic_d = pif.wrData;
      end
      unique case (act_q)
         lxgc_pkg::ACT_IDLE:
         begin
            if (actFall)
            begin
               act_d = lxgc_pkg::ACT_START; // RULE9
            end
         end
         lxgc_pkg::ACT_START:
         begin
            act_d = lxgc_pkg::ACT_WAIT;
         end
         lxgc_pkg::ACT_WAIT:
         begin
            if (activationDone)
            begin
               act_d = lxgc_pkg::ACT_IDLE;
               gdc_d[`LXGC_BIT_ACT_TRIG] = 1'b1; // RULE10
            end
         end
      endcase
      if (rstPrev_q)
      begin
         gdc_d[`LXGC_BIT_ACT_TRIG] = pif.sckS; // RULE11
      end
      if (softRst)
      begin
         // everything but the reset bit held at default, strap not sampled
         gdc_d = {`LXGC_GDC_SOFT | {7'h00, wrGdc & pif.wrData[`LXGC_BIT_RESET]}}; // RULE1 RULE3
         lic_d = `LXGC_LIC_RST; // RULE2
         act_d = lxgc_pkg::ACT_IDLE;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         gdc_q <= `LXGC_GDC_RST;
         lic_q <= `LXGC_LIC_RST; // RULE13
         act_q <= lxgc_pkg::ACT_IDLE;
         actPrev_q <= 1'b1;
         rstPrev_q <= 1'b1;
      end
      else
      begin
         gdc_q <= gdc_d;
         lic_q <= lic_d;
         act_q <= act_d;
         actPrev_q <= actPrev_d;
         rstPrev_q <= rstPrev_d;
      end
   end

   assign activationStart = (act_q == lxgc_pkg::ACT_START); // RULE9
   assign lineInterfaceConfig = lic_q;

   // registered control outputs
   logic txEn_q, txEn_d;
   logic coefClr_q, coefClr_d;
   logic [5:0] maint_q, maint_d;
   logic eocEn_q, eocEn_d;
   logic [7:0] eocAddr_q, eocAddr_d;
   logic [7:0] eocInfo_q, eocInfo_d;
   logic eocAcc_q, eocAcc_d;

   always_comb
   begin
      txEn_d = ~softRst; // RULE2
      coefClr_d = softRst; // RULE2
      maint_d = gdc_q[`LXGC_BIT_AUTO_MAINT] ? fsmMaintBits : maintenanceBitControlReg; // RULE5 RULE6
      eocEn_d = gdc_q[`LXGC_BIT_AUTO_OPS]; // RULE7
      eocAddr_d = eocEn_d ? 8'h00 : embeddedOpsAddressControl; // RULE7
      eocInfo_d = eocEn_d ? 8'h00 : embeddedOpsInfoControl; // RULE7
      eocAcc_d = eocEn_d & eocRxValid &
         (eocRxAddr == `LXGC_EOC_ADDR_A || eocRxAddr == `LXGC_EOC_ADDR_B); // RULE8
   end

   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         txEn_q <= 1'b0;
         coefClr_q <= 1'b1;
         maint_q <= 6'h00;
         eocEn_q <= 1'b1;
         eocAddr_q <= 8'h00;
         eocInfo_q <= 8'h00;
         eocAcc_q <= 1'b0;
      end
      else
      begin
         txEn_q <= txEn_d;
         coefClr_q <= coefClr_d;
         maint_q <= maint_d;
         eocEn_q <= eocEn_d;
         eocAddr_q <= eocAddr_d;
         eocInfo_q <= eocInfo_d;
         eocAcc_q <= eocAcc_d;
      end
   end

   assign lineTxEnable = txEn_q;
   assign filterCoefClear = coefClr_q;
   assign maintBitsOut = maint_q;
   assign embeddedOpsEngineEnable = eocEn_q;
   assign embeddedOpsAddrOut = eocAddr_q;
   assign embeddedOpsInfoOut = eocInfo_q;
   assign eocRxAccept = eocAcc_q;

   // output clock synthesis by phase accumulator, or from lineRateTick when rate is line and lineActive
   logic [NW-1:0] acc_q, acc_d;
   logic ck_q, ck_d;
   logic [1:0] rate;
   logic [NW:0] accSum;
   assign rate = gdc_q[`LXGC_BIT_RATE_LO +: 2];

   always_comb
   begin
      accSum = {1'b0, acc_q} + {1'b0, (rate == `LXGC_RATE_FREE) ? INC_FREE : INC_LINE};
      acc_d = accSum[NW-1:0];
      ck_d = ck_q;
      if (rate == `LXGC_RATE_LINE && lineActive)
      begin
         ck_d = ck_q ^ lineRateTick; // RULE4
      end
      else if (rate == `LXGC_RATE_LINE || rate == `LXGC_RATE_FREE)
      begin
         ck_d = ck_q ^ accSum[NW]; // RULE4
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         acc_q <= '0;
         ck_q <= 1'b0;
      end
      else
      begin
         acc_q <= acc_d;
         ck_q <= ck_d;
      end
   end

   assign dividedClockOutput = ck_q;
   assign dividedClockOutputOe = (rate == `LXGC_RATE_LINE) || (rate == `LXGC_RATE_FREE); // RULE4

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   sequence s_act_fall;
      (act_q == lxgc_pkg::ACT_IDLE) && actFall && !softRst;
   endsequence
   sequence s_act_pulse;
      activationStart ##1 !activationStart;
   endsequence

   a_soft_rst_defaults: assert property (softRst |=> lic_q == `LXGC_LIC_RST && !lineTxEnable) // RULE2
      else $error("soft reset did not restore defaults");
   a_soft_rst_hold: assert property (softRst && !(wrGdc && pif.wrData[0]) |=> softRst) // RULE3
      else $error("soft reset left without host write");
   a_soft_rst_enter: assert property (!softRst && wrGdc && !pif.wrData[0] |=> softRst ##1 filterCoefClear) // RULE1
      else $error("writing zero to reset bit did not reset");
   a_clk_tri_state: assert property (rate == `LXGC_RATE_TRI |-> !dividedClockOutputOe) // RULE4
      else $error("clock output driven in tristate code");
   a_clk_free_run: assert property (rate == `LXGC_RATE_FREE [*5] |-> $changed(ck_q) or $past(ck_q) != $past(ck_q, 4)) // RULE4
      else $error("free running clock not toggling");
   a_maint_select: assert property (!$past(sys_rst) |-> maintBitsOut ==
      ($past(gdc_q[3]) ? $past(fsmMaintBits) : $past(maintenanceBitControlReg))) // RULE5 RULE6
      else $error("maintenance bits from wrong source");
   a_eoc_addr_filter: assert property (eocRxAccept |-> $past(eocRxAddr) inside {3'h0, 3'h7}
      && $past(gdc_q[4])) // RULE8
      else $error("invalid embedded ops address accepted");
   a_eoc_manual_off: assert property (embeddedOpsEngineEnable |-> embeddedOpsAddrOut == 8'h00) // RULE7
      else $error("manual embedded ops register not ignored");
   a_act_start_once: assert property (s_act_fall |=> s_act_pulse) // RULE9
      else $error("activation attempt not started once");
   a_act_bit_restore: assert property (act_q == lxgc_pkg::ACT_WAIT && activationDone && !softRst
      |=> gdc_q[6] && act_q == lxgc_pkg::ACT_IDLE) // RULE10
      else $error("activation bit not set back");
   a_strap_act: assert property (rstPrev_q && !pif.sckS |=> !gdc_q[6] ##1 activationStart) // RULE11
      else $error("strap did not start activation");
   a_lic_reset: assert property ($fell(rstPrev_q) |-> $past(lic_q) == `LXGC_LIC_RST) // RULE13
      else $error("line interface config reset value wrong");
endmodule

/* File: lxgc_defs.svh */
// offsets, field positions, reset values and timing for the global control block
`ifndef LXGC_DEFS_SVH
`define LXGC_DEFS_SVH
`define LXGC_ADDR_W 5
`define LXGC_GDC_ADDR 5'h00
`define LXGC_LIC_ADDR 5'h01
`define LXGC_GDC_RST 8'hff
`define LXGC_GDC_SOFT 8'hfe
`define LXGC_LIC_RST 8'hef
`define LXGC_BIT_RESET 0
`define LXGC_BIT_RATE_LO 1
`define LXGC_BIT_AUTO_MAINT 3
`define LXGC_BIT_AUTO_OPS 4
`define LXGC_BIT_FIXED 5
`define LXGC_BIT_ACT_TRIG 6
`define LXGC_BIT_RW 7
`define LXGC_RATE_UNUSED 2'h0
`define LXGC_RATE_LINE 2'h1
`define LXGC_RATE_FREE 2'h2
`define LXGC_RATE_TRI 2'h3
`define LXGC_EOC_ADDR_A 3'h0
`define LXGC_EOC_ADDR_B 3'h7
`define LXGC_SYS_CLK_KHZ 100000
`define LXGC_LINE_CLK_KHZ 10240
`define LXGC_FREE_CLK_KHZ 15360
`define LXGC_NCO_W 24
`define LXGC_FRAME_BITS 16
`endif

/* File: lxgc_pkg.sv */
// types shared by the global control block
package lxgc_pkg;
   typedef enum logic [1:0] {ACT_IDLE, ACT_START, ACT_WAIT} lxgc_act_t;
endpackage

/* File: lxgc_port_if.sv */
// carrier between the serial frame engine and the register bank
`timescale 1ns/1ps
interface lxgc_port_if;
   logic sckS;
   logic sdiS;
   logic csNS;
   logic wrStb;
   logic [4:0] addr;
   logic [7:0] wrData;
   logic [7:0] rdData;
   logic sdo;
   logic sdoOe;
   modport port (input sckS, input sdiS, input csNS, input rdData,
      output wrStb, output addr, output wrData, output sdo, output sdoOe);
   modport regs (output sckS, output sdiS, output csNS, output rdData,
      input wrStb, input addr, input wrData, input sdo, input sdoOe);
endinterface

/* File: lxgc_serial_port.sv */
// two-byte serial frame engine: command byte then data byte, msb first
`timescale 1ns/1ps
`include "lxgc_defs.svh"
module lxgc_serial_port
(
   input wire logic clk_sys,
   lxgc_port_if.port pif
);
   logic [4:0] cnt_q, cnt_d;
   logic [7:0] shift_q, shift_d;
   logic [7:0] cmd_q, cmd_d;
   logic [7:0] dout_q, dout_d;
   logic sckPrev_q, sckPrev_d;
   logic sdo_q, sdo_d;
   logic wr_q, wr_d;
   logic [7:0] wrData_q, wrData_d;
   logic rise;
   logic fall;

   assign rise = pif.sckS & ~sckPrev_q;
   assign fall = ~pif.sckS & sckPrev_q;

   always_comb
   begin
      cnt_d = cnt_q;
      shift_d = shift_q;
      cmd_d = cmd_q;
      dout_d = dout_q;
      sckPrev_d = pif.sckS;
      sdo_d = sdo_q;
      wr_d = 1'b0;
      wrData_d = wrData_q;
      if (pif.csNS)
      begin
         cnt_d = 5'h00;
      end
      else if (rise && cnt_q < 5'(`LXGC_FRAME_BITS))
      begin
         shift_d = {shift_q[6:0], pif.sdiS};
         cnt_d = cnt_q + 5'h01;
         if (cnt_q == 5'h07)
         begin
            cmd_d = {shift_q[6:0], pif.sdiS};
         end
         if (cnt_q == 5'h0f && !cmd_q[`LXGC_BIT_RW])
         begin
            wr_d = 1'b1;
            wrData_d = {shift_q[6:0], pif.sdiS};
         end
      end
      else if (fall && cnt_q == 5'h08)
      begin
         sdo_d = pif.rdData[7];
         dout_d = {pif.rdData[6:0], 1'b0};
      end
      else if (fall && cnt_q > 5'h08)
      begin
         sdo_d = dout_q[7];
         dout_d = {dout_q[6:0], 1'b0};
      end
   end

   always_ff @(posedge clk_sys)
   begin
      cnt_q <= cnt_d;
      shift_q <= shift_d;
      cmd_q <= cmd_d;
      dout_q <= dout_d;
      sckPrev_q <= sckPrev_d;
      sdo_q <= sdo_d;
      wr_q <= wr_d;
      wrData_q <= wrData_d;
   end

   // frame is one command byte then write data or don't-care; device sends data only
   assign pif.addr = cmd_q[4:0]; // RULE14
   assign pif.wrStb = wr_q; // RULE14
   assign pif.wrData = wrData_q;
   assign pif.sdo = sdo_q;
   assign pif.sdoOe = ~pif.csNS & cmd_q[`LXGC_BIT_RW] & (cnt_q >= 5'h08); // RULE14
endmodule

/* File: lxgc_host_model.sv */
// host processor model driving the two-byte serial register frame
`timescale 1ns/1ps
module lxgc_host_model
(
   input wire logic clk_sys,
   input wire logic serialDataOut,
   input wire logic serialDataOutOe,
   output logic serialClk,
   output logic serialDataIn,
   output logic serialSelN
);
   // output enable seen at each read data bit of the last frame
   logic [7:0] oeBits;
   initial
   begin
      serialClk = 1'b0;
      serialDataIn = 1'b0;
      serialSelN = 1'b1;
   end
   task automatic wt(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   // serial clock level outside frames, also the strap seen at reset release
   task automatic park(input logic v);
      serialClk = v;
   endtask
   // command byte then data byte, msb first; read data taken on bits 9..16
   task automatic frame(input logic [7:0] cmd, input logic [7:0] wd, output logic [7:0] rd);
      logic [15:0] sh;
      sh = {cmd, wd};
      rd = 8'h00;
      oeBits = 8'h00;
      serialClk = 1'b0;
      serialSelN = 1'b0;
      for (int i = 15; i >= 0; i--)
      begin
         serialDataIn = sh[i];
         wt(5);
         serialClk = 1'b1;
         wt(5);
         if (i < 8)
         begin
            rd = {rd[6:0], serialDataOut};
            oeBits = {oeBits[6:0], serialDataOutOe};
         end
         serialClk = 1'b0;
      end
      wt(6);
      serialSelN = 1'b1;
      // released data line shows no stale bit
      serialDataIn = ~serialDataIn;
      wt(4);
   endtask
endmodule

/* File: tb_lxgc_top.sv */
// self-checking bench for the global control register bank
`timescale 1ns/1ps
`include "lxgc_defs.svh"
module tb_lxgc_top;
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   logic serialClk, serialDataIn, serialSelN, serialDataOut, serialDataOutOe;
   logic [7:0] lineInterfaceConfig, embeddedOpsAddrOut, embeddedOpsInfoOut;
   logic lineTxEnable, filterCoefClear, dividedClockOutput, dividedClockOutputOe;
   logic embeddedOpsEngineEnable, eocRxAccept, activationStart;
   logic [5:0] maintBitsOut;
   logic lineActive = 1'b0;
   logic lineRateTick = 1'b0;
   logic [5:0] maintenanceBitControlReg = 6'h00;
   logic [5:0] fsmMaintBits = 6'h00;
   logic [7:0] embeddedOpsAddressControl = 8'h00;
   logic [7:0] embeddedOpsInfoControl = 8'h00;
   logic [2:0] eocRxAddr = 3'h0;
   logic eocRxValid = 1'b0;
   logic activationDone = 1'b0;
   logic ckPrev = 1'b0;
   int tgl = 0;
   int err_total = 0;
   int compares = 0;
   int startCnt = 0;
   int tc = 0;
   always #5 clk_sys = ~clk_sys;
   always @(posedge clk_sys)
   begin
      tc <= (tc == 4) ? 0 : tc + 1;
      lineRateTick <= (tc == 4);
      ckPrev <= dividedClockOutput;
      if (dividedClockOutput !== ckPrev)
         tgl <= tgl + 1;
      if (activationStart === 1'b1)
         startCnt <= startCnt + 1;
   end
   lxgc_host_model lxgc_host_model_i (.clk_sys, .serialDataOut, .serialDataOutOe,
      .serialClk, .serialDataIn, .serialSelN);
   lxgc_top lxgc_top_i (.clk_sys, .sys_rst, .serialClk, .serialDataIn, .serialSelN,
      .serialDataOut, .serialDataOutOe, .lineInterfaceConfig, .lineTxEnable,
      .filterCoefClear, .dividedClockOutput, .dividedClockOutputOe, .lineActive,
      .lineRateTick, .maintenanceBitControlReg, .fsmMaintBits, .maintBitsOut,
      .embeddedOpsAddressControl, .embeddedOpsInfoControl, .embeddedOpsEngineEnable,
      .embeddedOpsAddrOut, .embeddedOpsInfoOut, .eocRxAddr, .eocRxValid, .eocRxAccept,
      .activationStart, .activationDone);
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp)
      begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      logic [7:0] r;
      lxgc_host_model_i.frame({3'h0, a}, d, r);
      chk("write oe", lxgc_host_model_i.oeBits, 8'h00);
   endtask
   task automatic rdc(input string nm, input logic [4:0] a, input logic [7:0] exp);
      logic [7:0] r;
      lxgc_host_model_i.frame({3'h4, a}, 8'h00, r);
      chk(nm, r, exp);
      chk("read oe", lxgc_host_model_i.oeBits, 8'hff);
   endtask
   // expected global config: reserved top bit and bit5 read 1
   function automatic logic [7:0] gval(logic [1:0] r, logic c, logic e, logic act);
      return {1'b1, act, 1'b1, e, c, r, 1'b1};
   endfunction
   // output clock toggles in 250 clocks: line tick every 5 clocks, nominal rate for line or free, none for other codes
   function automatic int ckexp(int r, logic la);
      if (r == 1 && la)
         return 50;
      if (r == 1)
         return 2 * `LXGC_LINE_CLK_KHZ * 250 / `LXGC_SYS_CLK_KHZ;
      if (r == 2)
         return 2 * `LXGC_FREE_CLK_KHZ * 250 / `LXGC_SYS_CLK_KHZ;
      return 0;
   endfunction
   task automatic hwrst(input logic sck);
      lxgc_host_model_i.park(sck);
      sys_rst = 1'b1;
      tick(6);
      chk("tx in reset", 8'(lineTxEnable), 8'h00);
      chk("coef clear", 8'(filterCoefClear), 8'h01);
      chk("clock oe rst", 8'(dividedClockOutputOe), 8'h00);
      sys_rst = 1'b0;
      tick(6);
      lxgc_host_model_i.park(1'b0);
   endtask
   task automatic done_pulse;
      activationDone = 1'b1;
      tick(1);
      activationDone = 1'b0;
      tick(3);
   endtask
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial
   begin
      #200_000;
      err_total++;
      conclude();
   end
   initial
   begin
      int s;
      int t0;
      int tg;
      int ex;
      logic [7:0] d;
      void'($urandom(7542));
      hwrst(1'b0);
      chk("strap start", 8'(startCnt), 8'h01);
      rdc("strap gdc", `LXGC_GDC_ADDR, 8'hbf);
      done_pulse();
      rdc("gdc after done", `LXGC_GDC_ADDR, 8'hff);
      rdc("lic reset", `LXGC_LIC_ADDR, 8'hef);
      rdc("unmapped", 5'h02, 8'h00);
      chk("tx after rst", 8'(lineTxEnable), 8'h01);
      hwrst(1'b1);
      chk("no strap", 8'(startCnt), 8'h01);
      $display("test reset done");
      for (int r = 0; r < 4; r++)
      begin
         lineActive = 1'($urandom);
         wr(`LXGC_GDC_ADDR, gval(2'(r), 1'b1, 1'b1, 1'b1));
         tick(2);
         chk("clock oe", 8'(dividedClockOutputOe), 8'(r == 1 || r == 2));
         t0 = tgl;
         tick(250);
         tg = tgl - t0;
         ex = ckexp(r, lineActive);
         chk("clock toggles", 8'(tg >= ex && tg <= ex + 1), 8'h01);
         rdc("gdc rate", `LXGC_GDC_ADDR, gval(2'(r), 1'b1, 1'b1, 1'b1));
      end
      $display("test rate done");
      for (int k = 0; k < 6; k++)
      begin
         wr(`LXGC_GDC_ADDR, gval(2'h3, 1'(k), 1'b1, 1'b1));
         maintenanceBitControlReg = 6'($urandom);
         fsmMaintBits = 6'($urandom);
         tick(2);
         d = 8'(k[0] ? fsmMaintBits : maintenanceBitControlReg);
         chk("maint bits", 8'(maintBitsOut), d);
      end
      $display("test maint done");
      for (int e = 0; e < 2; e++)
      begin
         wr(`LXGC_GDC_ADDR, gval(2'h3, 1'b1, 1'(e), 1'b1));
         embeddedOpsAddressControl = 8'($urandom);
         embeddedOpsInfoControl = 8'($urandom);
         tick(2);
         chk("eoc enable", 8'(embeddedOpsEngineEnable), 8'(e));
         chk("eoc addr", embeddedOpsAddrOut, e ? 8'h00 : embeddedOpsAddressControl);
         chk("eoc info", embeddedOpsInfoOut, e ? 8'h00 : embeddedOpsInfoControl);
         for (int a = 0; a < 8; a++)
         begin
            eocRxAddr = 3'(a);
            eocRxValid = 1'b1;
            tick(1);
            eocRxValid = 1'b0;
            chk("eoc accept", 8'(eocRxAccept), 8'(e && (a == 0 || a == 7)));
            tick(1);
         end
      end
      $display("test eoc done");
      s = startCnt;
      for (int n = 1; n < 3; n++)
      begin
         wr(`LXGC_GDC_ADDR, gval(2'h3, 1'b1, 1'b1, 1'b0));
         tick(4);
         chk("one attempt", 8'(startCnt - s), 8'(n));
         rdc("attempt busy", `LXGC_GDC_ADDR, 8'hbf);
         chk("no repeat", 8'(startCnt - s), 8'(n));
         done_pulse();
         rdc("attempt over", `LXGC_GDC_ADDR, 8'hff);
      end
      $display("test activation done");
      d = 8'($urandom);
      wr(`LXGC_LIC_ADDR, d);
      rdc("lic rw", `LXGC_LIC_ADDR, d);
      wr(`LXGC_GDC_ADDR, gval(2'h1, 1'b0, 1'b0, 1'b1));
      wr(`LXGC_GDC_ADDR, 8'hfe);
      tick(2);
      chk("soft tx", 8'(lineTxEnable), 8'h00);
      chk("soft coef", 8'(filterCoefClear), 8'h01);
      chk("soft lic", lineInterfaceConfig, 8'hef);
      chk("soft oe", 8'(dividedClockOutputOe), 8'h00);
      rdc("soft gdc", `LXGC_GDC_ADDR, 8'hfe);
      wr(`LXGC_LIC_ADDR, ~d);
      chk("lic held", lineInterfaceConfig, 8'hef);
      chk("still reset", 8'(lineTxEnable), 8'h00);
      wr(`LXGC_GDC_ADDR, 8'hff);
      tick(2);
      chk("soft release", 8'(lineTxEnable), 8'h01);
      chk("coef release", 8'(filterCoefClear), 8'h00);
      $display("test soft reset done");
      conclude();
   end
endmodule
